// ===== adc_cmd_pkg.sv
// constants and encodings for the command byte decoder
package adc_cmd_pkg;
  localparam int BYTE_BITS = 8;
  // register selection prefixes and how many leading bits identify them
  localparam int CONV_PREFIX_BIT = 7;
  localparam logic [1:0] SETUP_PREFIX = 2'h1;
  localparam logic [2:0] AVG_PREFIX = 3'h1;
  localparam logic [3:0] RESET_PREFIX = 4'h1;
  localparam logic [3:0] CONV_MIN_BITS = 4'h1;
  localparam logic [3:0] SETUP_MIN_BITS = 4'h2;
  localparam logic [3:0] AVG_MIN_BITS = 4'h3;
  // the reset command only acts once its type bit has arrived
  localparam logic [3:0] RESET_MIN_BITS = 4'h5;
  // conversion register fields
  localparam int CHAN_MSB = 6;
  localparam int CHAN_LSB = 3;
  localparam int SCAN_MSB = 2;
  localparam int SCAN_LSB = 1;
  // setup register fields
  localparam int CLK_MSB = 5;
  localparam int CLK_LSB = 4;
  localparam int REF_MSB = 3;
  localparam int REF_LSB = 2;
  // averaging register fields
  localparam int AVG_EN_BIT = 4;
  localparam int DEPTH_MSB = 3;
  localparam int DEPTH_LSB = 2;
  localparam int REPEAT_MSB = 1;
  localparam int REPEAT_LSB = 0;
  // reset command field
  localparam int RESET_TYPE_BIT = 3;
  // power-up images
  localparam logic [7:0] CONV_RESET = 8'h00;
  localparam logic [7:0] SETUP_RESET = 8'h20;
  localparam logic [7:0] AVG_RESET = 8'h00;
  // counts
  localparam logic [5:0] AVG_BASE = 6'h04;
  localparam logic [5:0] SINGLE_CONV = 6'h01;
  localparam int REPEAT_STEP_LOG2 = 2;
  // synchroniser reset levels: select high, byte toggle low, start pin high
  localparam logic [2:0] SYNC_RESET = 3'h5;

  typedef enum logic [1:0] {
    SCAN_UP_TO = 2'b00,
    SCAN_FROM = 2'b01,
    SCAN_REPEAT = 2'b10,
    SCAN_SINGLE = 2'b11
  } scan_mode_e;

  typedef enum logic [1:0] {
    CLK_PIN_INT_ACQ = 2'b00,
    CLK_PIN_EXT_ACQ = 2'b01,
    CLK_SERIAL_START = 2'b10,
    CLK_SERIAL_CLOCKED = 2'b11
  } clock_mode_e;

  typedef enum logic [1:0] {
    REF_INT_AUTO_OFF = 2'b00,
    REF_EXTERNAL = 2'b01,
    REF_INT_ALWAYS_ON = 2'b10,
    REF_RESERVED = 2'b11
  } ref_mode_e;
endpackage

// ===== adc_command_byte_decoder.sv
// serial command byte decoder driving scan configuration of a multichannel converter
// Summary of operation
// [RQ1] Command bytes arrive MSB first on rising serial clock, after select falls.
// [RQ2] Bit 7 set: conversion write, channel in bits 6..3, scan mode bits 2..1.
// [RQ3] Channel field is a plain binary index, 0 to 15.
// [RQ4] Scan mode 00 converts channels zero through selected channel.
// [RQ5] Scan mode 01 converts selected channel through highest channel.
// [RQ6] Scan mode 10 converts selected channel repeatedly; repeat field sets result count.
// [RQ7] Scan mode 11 converts selected channel once, one result.
// [RQ8] Clock modes 1x start on conversion write; modes 0x on start pin low pulse.
// [RQ9] Channel whose pin serves as convert start is never converted.
// [RQ10] Host never asks channels 8..15 on smaller variants.
// [RQ11] Prefix 01: setup write, clock mode bits 5..4, reference bits 3..2.
// [RQ12] Clock modes 00/01: internal clock, pin is start; 01 pin times acquisition.
// [RQ13] Mode 10 internal timing; 11 serial clock converts; shared pin stays analog.
// [RQ14] Upper clock mode bit resets to one.
// [RQ15] Reference 00 internal auto-off with wake delay, 01 external, 10 internal on.
// [RQ16] Host never programs reserved reference mode 11.
// [RQ17] Prefix 001: averaging write, enable bit 4, depth 3..2, repeat 1..0.
// [RQ18] Averaging off: one conversion per result.
// [RQ19] Averaging on: depth codes give 4, 8, 16 or 32 conversions per result.
// [RQ20] Repeat codes give 4, 8, 12, 16 results, only in scan mode 10.
// [RQ21] Averaging applies in every scan mode except clock mode 11.
// [RQ22] Prefix 0001: reset command, type in bit 3.
// [RQ23] Type one clears result FIFO only; type zero restores power-up defaults.
// [RQ24] Power-up: all registers zero except setup holding clock mode 10.
// [RQ25] Partial byte updates only received top bits; others keep old values.
// [RQ26] Byte with upper nibble zero is ignored without any state change.
`timescale 1ns/1ps
module adc_command_byte_decoder #(
  parameter int NUM_CHANNELS = 16,
  parameter int SHARED_CHANNEL = 15,
  parameter bit HAS_SHARED_PIN = 1'b1
) (
  // system clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // serial link from the host
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic din_i,
  // convert start pin, active low pulse
  input wire logic convert_start_pin_n_i,
  // register fields
  output logic [3:0] channel_select_o,
  output logic [1:0] scan_mode_o,
  output logic [1:0] clock_mode_o,
  output logic [1:0] reference_mode_o,
  output logic averaging_enable_o,
  output logic [1:0] average_depth_o,
  output logic [1:0] repeat_count_o,
  // derived scan control
  output logic [3:0] scan_first_o,
  output logic [3:0] scan_last_o,
  output logic [15:0] channel_mask_o,
  output logic [4:0] results_per_scan_o,
  output logic [5:0] conversions_per_result_o,
  output logic convert_start_pin_o,
  output logic acq_external_o,
  output logic serial_conv_clock_o,
  output logic ref_internal_o,
  output logic ref_always_on_o,
  output logic ref_wake_delay_o,
  // events
  output logic scan_start_o,
  output logic fifo_clear_o
);

  localparam logic [3:0] TOP_CHANNEL = 4'(NUM_CHANNELS - 1);
  localparam logic [3:0] SHARED_IDX = 4'(SHARED_CHANNEL);

  // ---------------- link clock domain ----------------
  logic [2:0] bit_cnt;
  logic [6:0] shift_reg;
  logic [7:0] byte_hold;
  logic byte_tgl;
  logic [7:0] part_data;
  logic [3:0] part_cnt;

  wire link_rst = ~rst_n_i;
  // select high aborts the byte in progress so the next frame starts aligned
  wire link_clr = cs_n_i | link_rst;
  wire [7:0] link_byte = {shift_reg, din_i};

  always_ff @(posedge sclk_i or posedge link_clr) begin
    if (link_clr) begin
      bit_cnt <= 3'h0;
      shift_reg <= 7'h00;
    end else begin
      bit_cnt <= bit_cnt + 3'h1; // RQ1
      shift_reg <= link_byte[6:0]; // RQ1
    end
  end

  // byte_hold and part_* stand still while select is high, when the system side reads them
  always_ff @(posedge sclk_i or posedge link_rst) begin
    if (link_rst) begin
      byte_hold <= 8'h00;
      byte_tgl <= 1'b0;
      part_data <= 8'h00;
      part_cnt <= 4'h0;
    end else begin
      part_data <= link_byte;
      if (bit_cnt == 3'h7) begin
        byte_hold <= link_byte; // RQ1
        byte_tgl <= ~byte_tgl;
        part_cnt <= 4'h0;
      end else begin
        part_cnt <= {1'b0, bit_cnt} + 4'h1; // RQ25
      end
    end
  end

  // ---------------- synchronisers into the system clock ----------------
  wire [2:0] sync_in = {cs_n_i, byte_tgl, convert_start_pin_n_i};
  logic [2:0] sync1;
  logic [2:0] sync2;
  logic [2:0] sync3;
  logic [2:0] filt;
  logic [2:0] filt_d;
  logic cs_rise_d;

  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_sync
      always_ff @(posedge clock_i) begin
        if (!rst_n_i) begin
          sync1[g] <= adc_cmd_pkg::SYNC_RESET[g];
          sync2[g] <= adc_cmd_pkg::SYNC_RESET[g];
          sync3[g] <= adc_cmd_pkg::SYNC_RESET[g];
          filt[g] <= adc_cmd_pkg::SYNC_RESET[g];
          filt_d[g] <= adc_cmd_pkg::SYNC_RESET[g];
        end else begin
          sync1[g] <= sync_in[g];
          sync2[g] <= sync1[g];
          sync3[g] <= sync2[g];
          // a change counts only once two stages agree
          if (sync2[g] == sync3[g]) begin
            filt[g] <= sync3[g];
          end
          filt_d[g] <= filt[g];
        end
      end
    end
  endgenerate

  wire byte_evt = filt[1] ^ filt_d[1];
  wire cs_rise = filt[2] & ~filt_d[2];
  wire pin_rise = filt[0] & ~filt_d[0];

  // the partial check waits a cycle so a full byte seen in the same cycle goes first
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      cs_rise_d <= 1'b0;
    end else begin
      cs_rise_d <= cs_rise;
    end
  end

  // ---------------- write decode ----------------
  wire part_evt = cs_rise_d & (part_cnt != 4'h0);
  wire wr_evt = byte_evt | part_evt;
  wire [3:0] wr_bits = byte_evt ? 4'h8 : part_cnt;
  wire [7:0] part_aligned = part_data << (4'h8 - part_cnt);
  wire [7:0] wr_data = byte_evt ? byte_hold : part_aligned;
  wire [7:0] wr_mask = ~(8'hFF >> wr_bits); // RQ25

  wire is_conv = wr_evt & (wr_bits >= adc_cmd_pkg::CONV_MIN_BITS)
    & wr_data[adc_cmd_pkg::CONV_PREFIX_BIT]; // RQ2
  wire is_setup = wr_evt & (wr_bits >= adc_cmd_pkg::SETUP_MIN_BITS)
    & (wr_data[7:6] == adc_cmd_pkg::SETUP_PREFIX); // RQ11
  wire is_avg = wr_evt & (wr_bits >= adc_cmd_pkg::AVG_MIN_BITS)
    & (wr_data[7:5] == adc_cmd_pkg::AVG_PREFIX); // RQ17
  wire is_reset = wr_evt & (wr_bits >= adc_cmd_pkg::RESET_MIN_BITS)
    & (wr_data[7:4] == adc_cmd_pkg::RESET_PREFIX); // RQ22
  // upper nibble all zero selects nothing and falls through
  wire is_none = wr_evt & ~is_conv & ~is_setup & ~is_avg & ~is_reset; // RQ26
  wire fifo_only = is_reset & wr_data[adc_cmd_pkg::RESET_TYPE_BIT]; // RQ23
  wire full_reset = is_reset & ~wr_data[adc_cmd_pkg::RESET_TYPE_BIT]; // RQ23

  logic [7:0] conv_reg;
  logic [7:0] setup_reg;
  logic [7:0] avg_reg;

  wire [7:0] merged = wr_data & wr_mask;
  wire [7:0] next_conv = merged | (conv_reg & ~wr_mask); // RQ25
  wire [7:0] next_setup = merged | (setup_reg & ~wr_mask); // RQ25
  wire [7:0] next_avg = merged | (avg_reg & ~wr_mask); // RQ25

  always_ff @(posedge clock_i) begin
    if (!rst_n_i || full_reset) begin
      conv_reg <= adc_cmd_pkg::CONV_RESET; // RQ24
      setup_reg <= adc_cmd_pkg::SETUP_RESET; // RQ14
      avg_reg <= adc_cmd_pkg::AVG_RESET; // RQ24
    end else begin
      if (is_conv) begin
        conv_reg <= next_conv;
      end
      if (is_setup) begin
        setup_reg <= next_setup;
      end
      if (is_avg) begin
        avg_reg <= next_avg;
      end
    end
  end

  // ---------------- field decode ----------------
  wire [3:0] chan = conv_reg[adc_cmd_pkg::CHAN_MSB:adc_cmd_pkg::CHAN_LSB]; // RQ3
  wire [1:0] scan = conv_reg[adc_cmd_pkg::SCAN_MSB:adc_cmd_pkg::SCAN_LSB];
  wire [1:0] clk_mode = setup_reg[adc_cmd_pkg::CLK_MSB:adc_cmd_pkg::CLK_LSB];
  wire [1:0] ref_mode = setup_reg[adc_cmd_pkg::REF_MSB:adc_cmd_pkg::REF_LSB];
  wire avg_en = avg_reg[adc_cmd_pkg::AVG_EN_BIT];
  wire [1:0] depth = avg_reg[adc_cmd_pkg::DEPTH_MSB:adc_cmd_pkg::DEPTH_LSB];
  wire [1:0] repeat_code = avg_reg[adc_cmd_pkg::REPEAT_MSB:adc_cmd_pkg::REPEAT_LSB];

  // modes 00 and 01 turn the shared pin into the start input
  wire pin_is_start = (clk_mode == adc_cmd_pkg::CLK_PIN_INT_ACQ)
    | (clk_mode == adc_cmd_pkg::CLK_PIN_EXT_ACQ); // RQ12 RQ13
  wire skip_active = pin_is_start & HAS_SHARED_PIN;

  wire [3:0] first = (scan == adc_cmd_pkg::SCAN_UP_TO) ? 4'h0 : chan; // RQ4
  wire [3:0] last = (scan == adc_cmd_pkg::SCAN_UP_TO) ? chan :
    (scan == adc_cmd_pkg::SCAN_FROM) ? TOP_CHANNEL : chan; // RQ5 RQ7

  wire [4:0] repeat_results = 5'(({3'h0, repeat_code} + 5'h01) << adc_cmd_pkg::REPEAT_STEP_LOG2); // RQ20
  wire [4:0] base_results = (scan == adc_cmd_pkg::SCAN_UP_TO) ? {1'b0, chan} + 5'h01 :
    (scan == adc_cmd_pkg::SCAN_FROM) ? {1'b0, TOP_CHANNEL} - {1'b0, chan} + 5'h01 :
    (scan == adc_cmd_pkg::SCAN_REPEAT) ? repeat_results : 5'h01; // RQ4 RQ5 RQ6 RQ7

  wire skip_hit = skip_active & (SHARED_IDX >= first) & (SHARED_IDX <= last); // RQ9
  // a single-channel scan on the start pin yields nothing at all
  wire [4:0] results = !skip_hit ? base_results :
    (scan[1] ? 5'h00 : base_results - 5'h01); // RQ9

  // serial-clocked conversions cannot average
  wire avg_eff = avg_en & (clk_mode != adc_cmd_pkg::CLK_SERIAL_CLOCKED); // RQ21
  wire [5:0] convs = avg_eff ? 6'(adc_cmd_pkg::AVG_BASE << depth)
    : adc_cmd_pkg::SINGLE_CONV; // RQ18 RQ19

  logic [15:0] mask;
  generate
    for (g = 0; g < 16; g++) begin : g_mask
      localparam logic [3:0] IDX = 4'(g);
      assign mask[g] = (g < NUM_CHANNELS) && (IDX >= first) && (IDX <= last)
        && !(skip_active && (IDX == SHARED_IDX)); // RQ9
    end
  endgenerate

  wire serial_start = byte_evt & is_conv & clk_mode[1]; // RQ8
  wire pin_start = pin_rise & pin_is_start; // RQ8

  // ---------------- registered outputs ----------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      channel_select_o <= 4'h0;
      scan_mode_o <= 2'h0;
      clock_mode_o <= adc_cmd_pkg::CLK_SERIAL_START;
      reference_mode_o <= 2'h0;
      averaging_enable_o <= 1'b0;
      average_depth_o <= 2'h0;
      repeat_count_o <= 2'h0;
      scan_first_o <= 4'h0;
      scan_last_o <= 4'h0;
      channel_mask_o <= 16'h0001;
      results_per_scan_o <= 5'h01;
      conversions_per_result_o <= adc_cmd_pkg::SINGLE_CONV;
      convert_start_pin_o <= 1'b0;
      acq_external_o <= 1'b0;
      serial_conv_clock_o <= 1'b0;
      ref_internal_o <= 1'b1;
      ref_always_on_o <= 1'b0;
      ref_wake_delay_o <= 1'b1;
      scan_start_o <= 1'b0;
      fifo_clear_o <= 1'b0;
    end else begin
      channel_select_o <= chan;
      scan_mode_o <= scan;
      clock_mode_o <= clk_mode;
      reference_mode_o <= ref_mode;
      averaging_enable_o <= avg_en;
      average_depth_o <= depth;
      repeat_count_o <= repeat_code;
      scan_first_o <= first;
      scan_last_o <= last;
      channel_mask_o <= mask;
      results_per_scan_o <= results;
      conversions_per_result_o <= convs;
      convert_start_pin_o <= pin_is_start; // RQ12
      acq_external_o <= clk_mode[0]; // RQ12 RQ13
      serial_conv_clock_o <= (clk_mode == adc_cmd_pkg::CLK_SERIAL_CLOCKED); // RQ13
      ref_internal_o <= (ref_mode != adc_cmd_pkg::REF_EXTERNAL); // RQ15
      ref_always_on_o <= (ref_mode == adc_cmd_pkg::REF_INT_ALWAYS_ON); // RQ15
      ref_wake_delay_o <= (ref_mode == adc_cmd_pkg::REF_INT_AUTO_OFF); // RQ15
      scan_start_o <= serial_start | pin_start; // RQ8
      fifo_clear_o <= is_reset; // RQ23
    end
  end

  // ---------------- assertions ----------------
  serial_start_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ8
    (byte_evt && is_conv && clk_mode[1]) |=> scan_start_o)
    else $error("conversion write in serial start mode gave no scan start");

  pin_start_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ8
    scan_start_o |-> $past(pin_rise && !clk_mode[1]) || $past(byte_evt && is_conv && clk_mode[1]))
    else $error("scan start without a valid cause");

  fifo_only_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ23
    fifo_only |=> fifo_clear_o && $stable(setup_reg) && $stable(conv_reg) && $stable(avg_reg))
    else $error("fifo clear command touched registers or gave no pulse");

  full_reset_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ24
    full_reset |=> (setup_reg == adc_cmd_pkg::SETUP_RESET) ##1
      (clock_mode_o == adc_cmd_pkg::CLK_SERIAL_START && channel_mask_o == 16'h0001))
    else $error("full reset did not restore power-up state");

  ignore_byte_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ26
    is_none |=> $stable(conv_reg) && $stable(setup_reg) && $stable(avg_reg) && !fifo_clear_o)
    else $error("unmatched byte changed state");

  partial_keep_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ25
    (part_evt && is_conv) |=> ((conv_reg & ~$past(wr_mask)) == ($past(conv_reg) & ~$past(wr_mask))))
    else $error("partial write altered bits that were not received");

  no_average_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ21
    (clock_mode_o == adc_cmd_pkg::CLK_SERIAL_CLOCKED) |-> (conversions_per_result_o == 6'h01))
    else $error("averaging active in serial clocked mode");

  repeat_count_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ20
    (scan_mode_o == adc_cmd_pkg::SCAN_REPEAT && !convert_start_pin_o)
      |-> (results_per_scan_o == 5'(({3'h0, repeat_count_o} + 5'h01) * 5'h04)))
    else $error("repeat scan result count wrong");

  shared_skip_a: assert property (@(posedge clock_i) disable iff (!rst_n_i) // RQ9
    (convert_start_pin_o && HAS_SHARED_PIN) |-> !channel_mask_o[SHARED_CHANNEL])
    else $error("start pin channel scheduled for conversion");

endmodule

// ===== adc_command_byte_decoder_tb.sv
// self-checking bench for the command byte decoder
`timescale 1ns/1ps
module adc_command_byte_decoder_tb;
  logic clock_i = 1'b0;
  logic rst_n_i = 1'b0;
  logic pin_n = 1'b1;
  logic sclk, cs_n, din;
  logic [3:0] channel_select, scan_first, scan_last;
  logic [1:0] scan_mode, clock_mode, reference_mode, average_depth, repeat_count;
  logic averaging_enable, convert_start_pin, acq_external, serial_conv_clock;
  logic ref_internal, ref_always_on, ref_wake_delay, scan_start, fifo_clear;
  logic [15:0] channel_mask;
  logic [4:0] results_per_scan;
  logic [5:0] conversions_per_result;
  wire logic [14:0] fields = {channel_select, scan_mode, clock_mode, reference_mode,
    averaging_enable, average_depth, repeat_count};
  int err_count = 0;
  int checks = 0;
  int pulses_start;
  int pulses_clear;

  always #5 clock_i = ~clock_i;

  // full 16-input variant, so channels 8..15 are legal requests
  adc_command_byte_decoder adc_command_byte_decoder_inst (
    .clock_i(clock_i), .rst_n_i(rst_n_i), .sclk_i(sclk), .cs_n_i(cs_n), .din_i(din),
    .convert_start_pin_n_i(pin_n), .channel_select_o(channel_select), .scan_mode_o(scan_mode),
    .clock_mode_o(clock_mode), .reference_mode_o(reference_mode),
    .averaging_enable_o(averaging_enable), .average_depth_o(average_depth),
    .repeat_count_o(repeat_count), .scan_first_o(scan_first), .scan_last_o(scan_last),
    .channel_mask_o(channel_mask), .results_per_scan_o(results_per_scan),
    .conversions_per_result_o(conversions_per_result), .convert_start_pin_o(convert_start_pin),
    .acq_external_o(acq_external), .serial_conv_clock_o(serial_conv_clock),
    .ref_internal_o(ref_internal), .ref_always_on_o(ref_always_on),
    .ref_wake_delay_o(ref_wake_delay), .scan_start_o(scan_start), .fifo_clear_o(fifo_clear)
  );

  spi_host_model spi_host_model_inst (
    .sclk_o(sclk),
    .cs_n_o(cs_n),
    .din_o(din)
  );

  task automatic give_verdict();
    if (err_count == 0 && checks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      err_count++;
      $display("MISMATCH %s expected %0h seen %0h", what, exp, seen);
    end
  endtask

  // covers the sync latency plus margin for the select high time
  task automatic settle();
    int i;
    pulses_start = 0;
    pulses_clear = 0;
    for (i = 0; i < 14; i++) begin
      @(posedge clock_i);
      #1;
      if (scan_start === 1'b1) begin
        pulses_start++;
      end
      if (fifo_clear === 1'b1) begin
        pulses_clear++;
      end
    end
  endtask

  task automatic send(input logic [7:0] value, input int nbits);
    spi_host_model_inst.send_bits(value, nbits);
    settle();
  endtask

  task automatic pin_pulse();
    @(posedge clock_i);
    #1 pin_n = 1'b0;
    repeat (4) @(posedge clock_i);
    #1 pin_n = 1'b1;
    settle();
  endtask

  // repeat code 3 and depth code 3 with averaging on are in force here
  task automatic conv_check(input logic [1:0] clk, input logic [3:0] ch, input logic [1:0] scan);
    logic [15:0] m;
    int lo, hi, c, n;
    lo = (scan == 2'h0) ? 0 : int'(ch);
    hi = (scan == 2'h1) ? 15 : int'(ch);
    m = 16'h0000;
    for (c = lo; c <= hi; c++) begin
      m[c] = 1'b1;
    end
    if (!clk[1]) begin
      m[15] = 1'b0;
    end
    n = (scan == 2'h2) ? 16 : $countones(m);
    send({1'h1, ch, scan, 1'h1}, 8);
    check("channel", 32'(channel_select), 32'(ch));
    check("scan mode", 32'(scan_mode), 32'(scan));
    check("mask", 32'(channel_mask), 32'(m));
    check("results", 32'(results_per_scan), 32'(n));
    check("first", 32'(scan_first), 32'(lo));
    check("last", 32'(scan_last), 32'(hi));
    check("convs", 32'(conversions_per_result), (clk == 2'h3) ? 32'h1 : 32'h20);
    check("serial starts", 32'(pulses_start), 32'(clk[1]));
  endtask

  initial begin
    #400000;
    err_count++;
    give_verdict();
  end

  initial begin
    logic [2:0] c, r, e, d;
    logic [14:0] snap;
    repeat (10) @(posedge clock_i);
    #1 rst_n_i = 1'b1;
    @(posedge clock_i);
    #1;
    check("power-up fields", 32'(fields), 32'h0100);
    check("power-up mask", 32'(channel_mask), 32'h1);
    check("power-up derived", 32'({results_per_scan, conversions_per_result, ref_internal,
      ref_wake_delay, convert_start_pin}), 32'h20E);
    // reserved reference code 3 is never programmed
    for (c = 3'h0; c < 3'h4; c++) begin
      for (r = 3'h0; r < 3'h3; r++) begin
        send({2'h1, c[1:0], r[1:0], 2'h3}, 8);
        check("clock mode", 32'(clock_mode), 32'(c));
        check("ref mode", 32'(reference_mode), 32'(r));
        check("start pin", 32'(convert_start_pin), 32'(c < 3'h2));
        check("ext acq", 32'(acq_external), 32'(c[0]));
        check("serial clk", 32'(serial_conv_clock), 32'(c == 3'h3));
        check("ref flags", 32'({ref_internal, ref_always_on, ref_wake_delay}),
          32'({r != 3'h1, r == 3'h2, r == 3'h0}));
      end
    end
    send(8'h28, 8);
    send(8'hAD, 8);
    // leave serial clocked mode, which would suppress averaging
    send(8'h60, 8);
    for (e = 3'h0; e < 3'h2; e++) begin
      for (d = 3'h0; d < 3'h4; d++) begin
        for (r = 3'h0; r < 3'h4; r++) begin
          send({3'h1, e[0], d[1:0], r[1:0]}, 8);
          check("avg fields", 32'({averaging_enable, average_depth, repeat_count}),
            32'({e[0], d[1:0], r[1:0]}));
          check("convs", 32'(conversions_per_result), e[0] ? (32'h4 << d) : 32'h1);
          check("repeats", 32'(results_per_scan), 32'h4 * (32'(r) + 32'h1));
        end
      end
    end
    for (c = 3'h0; c < 3'h4; c++) begin
      send({2'h1, c[1:0], 4'h8}, 8);
      for (r = 3'h0; r < 3'h4; r++) begin
        conv_check(c[1:0], 4'hC, r[1:0]);
        conv_check(c[1:0], 4'h3, r[1:0]);
      end
      pin_pulse();
      check("pin starts", 32'(pulses_start), 32'(c < 3'h2));
    end
    // partial write keeps the low bits of the previous byte
    send(8'hAF, 8);
    send(8'h90, 4);
    check("partial chan", 32'(channel_select), 32'h3);
    check("partial scan", 32'(scan_mode), 32'h3);
    check("partial start", 32'(pulses_start), 32'h0);
    snap = fields;
    send(8'h0F, 8);
    check("ignored", 32'(fields), 32'(snap));
    check("ignored pulses", 32'(pulses_start + pulses_clear), 32'h0);
    send(8'h1F, 8);
    check("fifo clear", 32'(pulses_clear), 32'h1);
    check("fifo keeps", 32'(fields), 32'(snap));
    send(8'h10, 8);
    check("full reset clear", 32'(pulses_clear), 32'h1);
    check("full reset", 32'(fields), 32'h0100);
    check("full reset mask", 32'(channel_mask), 32'h1);
    give_verdict();
  end
endmodule

// ===== spi_host_model.sv
// serial host model that shifts command bytes into the decoder
`timescale 1ns/1ps
module spi_host_model #(
  parameter real HALF_NS = 7.5
) (
  // serial link to the device
  output logic sclk_o,
  output logic cs_n_o,
  output logic din_o
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    din_o = 1'b0;
  end

  // top nbits of value go out msb first; fewer than eight makes a partial write
  task automatic send_bits(input logic [7:0] value, input int nbits);
    int i;
    #3.3;
    cs_n_o = 1'b0;
    for (i = 7; i > 7 - nbits; i--) begin
      din_o = value[i];
      #(HALF_NS);
      sclk_o = 1'b1;
      #(HALF_NS);
      sclk_o = 1'b0;
    end
    // clock stays low between frames; released data shows no stale bit
    cs_n_o = 1'b1;
    din_o = ~din_o;
  endtask
endmodule
